// *** hw/counter_array_pkg.sv ***
/*
 Constants for the counter array: register map, field positions,
 reset values, count-source encodings and prescaler divisors.
 Assumes a 200 MHz pclk that stands for the oscillator.
*/
package counter_array_pkg;

   // Bus address width and register map (byte addresses)
   localparam int          addr_width          = 8;
   localparam logic [7:0]  addr_mode           = 8'h00;
   localparam logic [7:0]  addr_control        = 8'h04;
   localparam logic [7:0]  addr_count_low      = 8'h08;
   localparam logic [7:0]  addr_count_high     = 8'h0c;
   localparam logic [7:0]  addr_module_base    = 8'h20;
   localparam logic [7:0]  addr_module_stride  = 8'h10;
   localparam logic [7:0]  offs_function       = 8'h00;
   localparam logic [7:0]  offs_value_low      = 8'h04;
   localparam logic [7:0]  offs_value_high     = 8'h08;

   // Counter mode register fields
   localparam int          mode_idle_stop      = 7;
   localparam int          mode_watchdog       = 6;
   localparam int          mode_src_hi         = 2;
   localparam int          mode_src_lo         = 1;
   localparam int          mode_ovf_irq_en     = 0;
   localparam logic [7:0]  mode_write_mask     = 8'hc7;

   // Counter control register fields
   localparam int          ctrl_ovf_flag       = 7;
   localparam int          ctrl_run            = 6;

   // Module function select fields
   localparam int          fs_irq_en           = 0;
   localparam int          fs_pwm              = 1;
   localparam int          fs_toggle           = 2;
   localparam int          fs_match            = 3;
   localparam int          fs_cap_fall         = 4;
   localparam int          fs_cap_rise         = 5;
   localparam int          fs_comparator       = 6;
   localparam logic [7:0]  fs_write_mask       = 8'h7f;

   // Reset values
   localparam logic [7:0]  reg_reset           = 8'h00;
   localparam logic [15:0] value_reset         = 16'h0000;

   // Count source encodings
   localparam logic [1:0]  src_osc_slow        = 2'b00;
   localparam logic [1:0]  src_osc_fast        = 2'b01;
   localparam logic [1:0]  src_timer0          = 2'b10;
   localparam logic [1:0]  src_ext_pin         = 2'b11;

   // Prescaler divisors in oscillator cycles
   localparam logic [3:0]  div_slow_6clk       = 4'h6;
   localparam logic [3:0]  div_slow_12clk      = 4'hc;
   localparam logic [3:0]  div_fast_6clk       = 4'h2;
   localparam logic [3:0]  div_fast_12clk      = 4'h4;

   // Port-1 placement and special module
   localparam int          first_module_pin    = 3;
   localparam int          ext_count_pin       = 2;
   localparam int          watchdog_module     = 4;
   localparam int          max_modules         = 5;

   // Counter edge values
   localparam logic [15:0] count_top           = 16'hffff;
   localparam logic [7:0]  low_top             = 8'hff;

endpackage

// *** hw/counter_array.sv ***
/*
 Counter array: one shared 16-bit up-counter and up to five
 capture/compare modules on port-1 pins, reached over APB.
 Assumes all inputs are synchronous to pclk except the port-1 pins,
 which are synchronised here; timer0_overflow is a one-cycle pulse.
 A watchdog match pulses internal_reset and also sets the flag of module four.
*/
// Operation
// - Source select picks oscillator divide, timer0, pin
// - One 16-bit counter shared by all modules
// - Counter runs only while run bit set
// - Overflow sets flag; interrupt when enabled
// - Only software clears the overflow flag
// - Module flags set by hardware, software-cleared
// - Idle-stop halts counting during processor idle
// - Module irq enable gates its flag
// - Toggle bit inverts pin on compare match
// - Match enable sets flag on compare match
// - Falling and rising capture edge enables
// - Comparator enable gates all compare functions
// - Enabled edge copies counter into value, flags
// - Comparator plus match gives software timer
// - Adding toggle gives high-speed output
// - PWM output low while low byte below compare
// - Low byte wrap reloads compare low from high
// - Watchdog enable applies to module four only
// - Module pins from port-1 bit 3; count on 2
// - Watchdog match raises internal reset and module four's flag
`timescale 1ns/1ps
`default_nettype none

module counter_array #(
   parameter int num_modules = 5
) (
   // Clock and reset
   input  wire  logic                                  pclk,
   input  wire  logic                                  presetn,
   // APB slave
   input  wire  logic                                  psel,
   input  wire  logic                                  penable,
   input  wire  logic                                  pwrite,
   input  wire  logic [counter_array_pkg::addr_width-1:0] paddr,
   input  wire  logic [31:0]                           pwdata,
   output logic [31:0]                                 prdata,
   output logic                                        pready,
   output logic                                        pslverr,
   // Core status
   input  wire  logic                                  six_clock_mode,
   input  wire  logic                                  idle_mode,
   input  wire  logic                                  timer0_overflow,
   // Port 1 pins
   input  wire  logic [7:0]                            port1_in,
   output logic [7:0]                                  port1_out,
   output logic [7:0]                                  port1_oe,
   // Requests to the core
   output logic                                        irq,
   output logic                                        internal_reset
);
   import counter_array_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Parameter check

   // At most five module pins fit, port-1 bits 3 to 7
   if (num_modules < 1 || num_modules > max_modules) begin : g_check
      $error("num_modules must lie between 1 and 5");
   end

   ////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      // Software registers
      logic [7:0]                        mode;
      logic [7:0]                        control;
      logic [15:0]                       count;
      logic [num_modules-1:0][7:0]       fsel;
      logic [num_modules-1:0][15:0]      value;
      // Prescaler and pin samples
      logic [3:0]                        presc;
      logic [num_modules-1:0]            pin_s1;
      logic [num_modules-1:0]            pin_s2;
      logic [num_modules-1:0]            pin_s3;
      logic                              eci_s1;
      logic                              eci_s2;
      logic                              eci_s3;
      logic                              tick;
      // Registered outputs
      logic [7:0]                        p1_out;
      logic [7:0]                        p1_oe;
      logic                              irq;
      logic                              wdt_rst;
      // Bus answer
      logic [31:0]                       prdata;
      logic                              pready;
      logic                              pslverr;
   } state_type;

   state_type s_q;
   state_type s_d;

   ////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      // Counter path
      logic [3:0]  div;
      logic        osc_tick;
      logic        src_tick;
      logic        tick;
      logic        ovf;
      // Flags and bus decode
      logic [7:0]  flag_set;
      logic [7:0]  ma;
      logic        hit;
      logic        wr;
      logic        rd_cycle;
      logic [7:0]  rdv;
      logic [7:0]  wd;
      // Per-module, reused each pass
      logic        rise;
      logic        fall;
      logic        match;
      logic        wdt_hit;
      logic        any_irq;
      logic [7:0]  fs;

      // Defaults, then held state
      div      = div_slow_12clk;
      osc_tick = 1'b0;
      src_tick = 1'b0;
      tick     = 1'b0;
      ovf      = 1'b0;
      flag_set = reg_reset;
      ma       = addr_module_base;
      hit      = 1'b0;
      wr       = 1'b0;
      rd_cycle = 1'b0;
      rdv      = reg_reset;
      wd       = pwdata[7:0];
      rise     = 1'b0;
      fall     = 1'b0;
      match    = 1'b0;
      wdt_hit  = 1'b0;
      any_irq  = 1'b0;
      fs       = reg_reset;
      s_d      = s_q;

      // Pin synchronisers, module pins from bit 3 upward
      for (int i = 0; i < num_modules; i++) begin
         s_d.pin_s1[i] = port1_in[first_module_pin + i];
      end
      // Only stages 2 and 3 are compared
      s_d.pin_s2 = s_q.pin_s1;
      s_d.pin_s3 = s_q.pin_s2;
      s_d.eci_s1 = port1_in[ext_count_pin];
      s_d.eci_s2 = s_q.eci_s1;
      s_d.eci_s3 = s_q.eci_s2;

      // Prescaler divisor from source and clock mode
      if (s_q.mode[mode_src_hi:mode_src_lo] == src_osc_slow) begin
         div = six_clock_mode ? div_slow_6clk : div_slow_12clk;
      end else begin
         div = six_clock_mode ? div_fast_6clk : div_fast_12clk;
      end

      // Free-running; >= copes with a smaller div
      if (s_q.presc >= div - 4'h1) begin
         osc_tick  = 1'b1;
         s_d.presc = 4'h0;
      end else begin
         s_d.presc = s_q.presc + 4'h1;
      end

      // Count source select
      // The pin counts rising edges only
      case (s_q.mode[mode_src_hi:mode_src_lo])
         src_osc_slow: src_tick = osc_tick;
         src_osc_fast: src_tick = osc_tick;
         src_timer0:   src_tick = timer0_overflow;
         default:      src_tick = s_q.eci_s2 & ~s_q.eci_s3;
      endcase

      // Counter advance, gated by run and idle-stop
      tick = src_tick & s_q.control[ctrl_run]
             & ~(s_q.mode[mode_idle_stop] & idle_mode);
      // Compares look at the stepped count
      s_d.tick = tick;

      // Overflow seen once per wrap
      if (tick) begin
         s_d.count = s_q.count + 16'h0001;
         ovf       = (s_q.count == count_top);
      end

      // Per-module compare, toggle, PWM and watchdog
      for (int i = 0; i < num_modules; i++) begin
         fs    = s_q.fsel[i];
         // Edges from stages 2 and 3
         rise  = s_q.pin_s2[i] & ~s_q.pin_s3[i];
         fall  = ~s_q.pin_s2[i] & s_q.pin_s3[i];
         // One compare per count value
         match = s_q.tick & fs[fs_comparator]
                 & (s_q.count == s_q.value[i]);

         // Match sets the flag: software timer
         if (match && fs[fs_match]) begin
            flag_set[i] = 1'b1;
         end

         // Toggle on match: high-speed output
         if (match && fs[fs_toggle] && !fs[fs_pwm]) begin
            s_d.p1_out[first_module_pin + i] =
               ~s_q.p1_out[first_module_pin + i];
         end

         // PWM level from the low byte
         if (fs[fs_pwm] && fs[fs_comparator]) begin
            s_d.p1_out[first_module_pin + i] =
               (s_q.count[7:0] >= s_q.value[i][7:0]);
            if (tick && s_q.count[7:0] == low_top) begin
               s_d.value[i][7:0] = s_q.value[i][15:8];
            end
         end

         // Pin driven only in output functions
         s_d.p1_oe[first_module_pin + i] = fs[fs_comparator]
            & (fs[fs_toggle] | fs[fs_pwm]);

         // Watchdog on module four
         if (i == watchdog_module && match && fs[fs_match]
             && s_q.mode[mode_watchdog]) begin
            wdt_hit = 1'b1;
         end
      end

      // Bus decode
      // Wait state before ready
      rd_cycle = psel & penable & ~s_q.pready;
      if (paddr == addr_mode) begin
         hit = 1'b1;
         rdv = s_q.mode;
      end else if (paddr == addr_control) begin
         hit = 1'b1;
         rdv = s_q.control;
      end else if (paddr == addr_count_low) begin
         hit = 1'b1;
         rdv = s_q.count[7:0];
      end else if (paddr == addr_count_high) begin
         hit = 1'b1;
         rdv = s_q.count[15:8];
      end else begin
         // Modules, one stride apart
         for (int i = 0; i < num_modules; i++) begin
            ma = addr_module_base + (addr_module_stride * 8'(i));
            if (paddr == ma + offs_function) begin
               hit = 1'b1;
               rdv = s_q.fsel[i];
            end else if (paddr == ma + offs_value_low) begin
               hit = 1'b1;
               rdv = s_q.value[i][7:0];
            end else if (paddr == ma + offs_value_high) begin
               hit = 1'b1;
               rdv = s_q.value[i][15:8];
            end
         end
      end

      // Writes land while ready is high
      wr = psel & penable & s_q.pready & pwrite & hit;

      // Register writes
      if (wr) begin
         if (paddr == addr_mode) begin
            // Bits 5..3 stay zero
            s_d.mode = wd & mode_write_mask;
         end else if (paddr == addr_control) begin
            s_d.control[ctrl_run] = wd[ctrl_run];
            // Writing zero clears; ones keep flags
            s_d.control[ctrl_ovf_flag] =
               s_q.control[ctrl_ovf_flag] & wd[ctrl_ovf_flag];
            s_d.control[num_modules-1:0] =
               s_q.control[num_modules-1:0] & wd[num_modules-1:0];
         end else if (paddr == addr_count_low) begin
            // Either byte loads at any time
            s_d.count[7:0] = wd;
         end else if (paddr == addr_count_high) begin
            s_d.count[15:8] = wd;
         end else begin
            // Same map as the read decode
            for (int i = 0; i < num_modules; i++) begin
               ma = addr_module_base + (addr_module_stride * 8'(i));
               if (paddr == ma + offs_function) begin
                  s_d.fsel[i] = wd & fs_write_mask;
               end else if (paddr == ma + offs_value_low) begin
                  s_d.value[i][7:0] = wd;
               end else if (paddr == ma + offs_value_high) begin
                  s_d.value[i][15:8] = wd;
               end
            end
         end
      end

      // Capture overrides a software value write
      for (int i = 0; i < num_modules; i++) begin
         fs   = s_q.fsel[i];
         rise = s_q.pin_s2[i] & ~s_q.pin_s3[i];
         fall = ~s_q.pin_s2[i] & s_q.pin_s3[i];
         if ((fs[fs_cap_rise] && rise) || (fs[fs_cap_fall] && fall)) begin
            // Count before this step
            s_d.value[i] = s_q.count;
            flag_set[i]  = 1'b1;
         end
      end

      // Hardware set wins over software clear
      if (ovf) begin
         s_d.control[ctrl_ovf_flag] = 1'b1;
      end

      // This cycle's module events
      s_d.control[num_modules-1:0] =
         s_d.control[num_modules-1:0] | flag_set[num_modules-1:0];

      // Shared interrupt request
      any_irq = s_q.control[ctrl_ovf_flag] & s_q.mode[mode_ovf_irq_en];
      for (int i = 0; i < num_modules; i++) begin
         any_irq = any_irq
                   | (s_q.control[i] & s_q.fsel[i][fs_irq_en]);
      end

      // Requests leave from flip-flops
      s_d.irq     = any_irq;
      s_d.wdt_rst = wdt_hit;

      // Bus answer: one wait cycle, then ready
      s_d.pready = rd_cycle;
      // Valid only in the ready cycle
      if (rd_cycle) begin
         s_d.prdata  = {24'h000000, rdv};
         s_d.pslverr = ~hit;
      end else if (s_q.pready) begin
         s_d.prdata  = 32'h00000000;
         s_d.pslverr = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Counter stopped, pins released
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops

   assign prdata         = s_q.prdata;
   assign pready         = s_q.pready;
   assign pslverr        = s_q.pslverr;
   assign port1_out      = s_q.p1_out;
   assign port1_oe       = s_q.p1_oe;
   assign irq            = s_q.irq;
   assign internal_reset = s_q.wdt_rst;

endmodule

`default_nettype wire

// *** sim/counter_array_monitor.sv ***
/*
 Port checker for the counter array: APB answer timing, spare pins,
 watchdog pulse shape and what may change a flag or a pin mode.
 Assumes it is bound onto every counter_array instance.
*/
`timescale 1ns/1ps
`default_nettype none

module counter_array_monitor (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins and requests
   input wire logic [7:0]  port1_out,
   input wire logic [7:0]  port1_oe,
   input wire logic        irq,
   input wire logic        internal_reset
);
   logic [3:0] wr_hist_q;

   ////////////////////////////////////////////////////////////////////////
   // Completed writes over the last four cycles; only software may drop a flag or a mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_hist_q <= 4'h0;
      end else begin
         wr_hist_q <= {wr_hist_q[2:0], pready & pwrite};
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Access phase waits one cycle, then the answer stands one cycle
   sequence s_waiting;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence

   ////////////////////////////////////////////////////////////////////////
   a_access_answered: assert property (s_waiting |=> s_answer)
      else $error("access not answered after one wait cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_error_with_ready: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("read data not zero outside answer");
   a_read_byte_wide: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_spare_pins_quiet: assert property (port1_out[2:0] == 3'h0 && port1_oe[2:0] == 3'h0)
      else $error("pin below module 0 driven");
   a_reset_one_pulse: assert property (internal_reset |=> !internal_reset)
      else $error("internal reset longer than one cycle");
   a_flag_soft_clear: assert property ($fell(irq) |-> |wr_hist_q)
      else $error("request dropped without a software write");
   a_mode_from_write: assert property ($changed(port1_oe) |-> |wr_hist_q)
      else $error("pin enable changed without a software write");
endmodule

bind counter_array counter_array_monitor u_monitor (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .port1_out(port1_out),
   .port1_oe(port1_oe), .irq(irq), .internal_reset(internal_reset));

`default_nettype wire

// *** sim/pin_model.sv ***
/*
 Outside world on port 1: each pin shows the block's level while the
 block enables it, else the level the bench applies from outside.
 Assumes strong external drivers, so no pull levels are modelled.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_model (
   // Block side
   input  wire logic [7:0] port1_out,
   input  wire logic [7:0] port1_oe,
   // Far side
   input  wire logic [7:0] ext_level,
   output logic      [7:0] pins
);
   // Block wins a pin only while its enable is high
   assign pins = (port1_oe & port1_out) | (~port1_oe & ext_level);
endmodule

`default_nettype wire

// *** sim/counter_array_bench.sv ***
/*
 Self-checking bench for the counter array, driven over APB.
 Assumes the pin model and the bound port checker compile beside it.
*/
`timescale 1ns/1ps
`default_nettype none

module counter_array_bench;
   import counter_array_pkg::*;
   localparam logic [7:0] m_t0 = 8'(src_timer0) << mode_src_lo;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic        six_clock_mode, idle_mode, timer0_overflow, internal_reset, wd_seen;
   logic [7:0]  paddr, port1_out, port1_oe, ext_level, pins;
   logic [31:0] pwdata, prdata;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   logic [15:0] r;
   int          n_mismatch, num_checks;

   counter_array u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .six_clock_mode(six_clock_mode), .idle_mode(idle_mode),
      .timer0_overflow(timer0_overflow), .port1_in(pins), .port1_out(port1_out),
      .port1_oe(port1_oe), .irq(irq), .internal_reset(internal_reset));
   pin_model u_pins (.port1_out(port1_out), .port1_oe(port1_oe), .ext_level(ext_level),
      .pins(pins));

   ////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // Watches answers against the oldest note, and catches watchdog pulses
   always @(posedge pclk) begin
      if (internal_reset) wd_seen <= 1'b1;
      if (psel && penable && pready) begin
         if (exp_q.size() == 0) begin
            chk("answer", 32'h1, 32'h0);
         end else begin
            e = exp_q.pop_front();
            chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
            if (!pwrite) chk("prdata", prdata, e[31:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
      num_checks++;
      if (seen !== x) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, x, seen);
      end
   endtask

   task chk1(input string nm, input logic seen, input logic x);
      chk(nm, {31'h0, seen}, {31'h0, x});
   endtask

   task complete_run;
      $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // One APB transfer; the note goes on the queue before it starts
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
      int n;
      n = 0;
      exp_q.push_back(x);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_mismatch++;
         complete_run;
      end else begin
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h0, d}, 33'h0);
   endtask

   task rd(input logic [7:0] a, input logic [7:0] x);
      xfer(1'b0, a, 32'h0, {25'h0, x});
   endtask

   task set_count(input logic [15:0] v);
      wr(addr_count_low, v[7:0]);
      wr(addr_count_high, v[15:8]);
      repeat (3) @(posedge pclk);
   endtask

   task pulse(input int k);
      repeat (k) begin
         @(posedge pclk);
         timer0_overflow <= 1'b1;
         @(posedge pclk);
         timer0_overflow <= 1'b0;
      end
      repeat (4) @(posedge pclk);
   endtask

   task pin_edge(input int b, input logic v);
      @(posedge pclk);
      ext_level[b] <= v;
      repeat (6) @(posedge pclk);
   endtask

   function automatic logic [7:0] ma(input int n, input logic [7:0] o);
      return addr_module_base + 8'(n) * addr_module_stride + o;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {psel, penable, pwrite, six_clock_mode, idle_mode, timer0_overflow} = 6'h00;
      {presetn, wd_seen, paddr, ext_level, pwdata} = 50'h0;
      r = 16'($urandom(67950));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, then an unmapped place refused both ways
      for (int n = 0; n < 5; n++) begin
         for (int k = 0; k < 3; k++) rd(ma(n, 8'(4 * k)), reg_reset);
      end
      rd(addr_control, reg_reset);
      xfer(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
      xfer(1'b1, 8'h10, 32'hff, {1'b1, 32'h0});
      // Access kinds: masked bits, random values, flags not settable
      wr(addr_mode, 8'hff);
      rd(addr_mode, mode_write_mask);
      for (int n = 0; n < 5; n++) begin
         r = 16'($urandom);
         wr(ma(n, offs_function), 8'hff);
         rd(ma(n, offs_function), fs_write_mask);
         wr(ma(n, offs_function), 8'h00);
         wr(ma(n, offs_value_low), r[7:0]);
         wr(ma(n, offs_value_high), r[15:8]);
         rd(ma(n, offs_value_high), r[15:8]);
      end
      // Each PWM level above captured its own rise
      rd(addr_control, 8'h1f);
      wr(addr_control, 8'h00);
      wr(addr_control, 8'h1f);
      rd(addr_control, 8'h00);
      $display("Test registers finished");
      // Counting from timer 0 and the count pin, gated by run and idle stop
      wr(addr_mode, m_t0);
      set_count(16'h0000);
      pulse(3);
      rd(addr_count_low, 8'h00);
      wr(addr_control, 8'h40);
      pulse(5);
      rd(addr_count_low, 8'h05);
      idle_mode <= 1'b1;
      pulse(2);
      rd(addr_count_low, 8'h07);
      wr(addr_mode, m_t0 | 8'h80);
      pulse(2);
      rd(addr_count_low, 8'h07);
      idle_mode <= 1'b0;
      wr(addr_mode, 8'(src_ext_pin) << mode_src_lo);
      for (int k = 0; k < 8; k++) pin_edge(2, ~k[0]);
      rd(addr_count_low, 8'h0b);
      $display("Test counting finished");
      // Overflow flag and request; software alone clears the flag
      wr(addr_mode, m_t0 | 8'h01);
      set_count(16'hffff);
      pulse(1);
      rd(addr_count_high, 8'h00);
      rd(addr_control, 8'hc0);
      chk1("irq", irq, 1'b1);
      wr(addr_control, 8'hc0);
      rd(addr_control, 8'hc0);
      wr(addr_control, 8'h40);
      repeat (2) @(posedge pclk);
      chk1("irq", irq, 1'b0);
      wr(addr_mode, m_t0);
      // Capture on falling, rising and both edges of module 0
      for (int k = 1; k < 4; k++) begin
         r = 16'($urandom);
         wr(ma(0, offs_function), 8'(k << fs_cap_fall) | 8'h01);
         wr(ma(0, offs_value_low), 8'h00);
         wr(ma(0, offs_value_high), 8'h00);
         set_count(r);
         pin_edge(3, 1'b1);
         rd(ma(0, offs_value_low), k[1] ? r[7:0] : 8'h00);
         set_count(~r);
         pin_edge(3, 1'b0);
         rd(ma(0, offs_value_high), k[0] ? ~r[15:8] : r[15:8]);
         chk1("irq", irq, 1'b1);
         rd(addr_control, 8'h41);
         wr(addr_control, 8'h40);
      end
      $display("Test capture finished");
      // Toggle on module 1: comparator off, then two matches from the high PWM level
      wr(ma(1, offs_value_low), 8'h03);
      wr(ma(1, offs_value_high), 8'h00);
      for (int k = 0; k < 3; k++) begin
         wr(ma(1, offs_function), k ? 8'h4c : 8'h0c);
         set_count(16'h0000);
         pulse(3);
         chk1("pin", port1_out[4], k != 1);
         chk1("oe", port1_oe[4], k != 0);
         rd(addr_control, k ? 8'h42 : 8'h40);
         wr(addr_control, 8'h40);
      end
      // PWM of module 2 at the compare boundary and the wrap reload
      wr(ma(2, offs_function), 8'h42);
      wr(ma(2, offs_value_low), 8'h80);
      wr(ma(2, offs_value_high), 8'h40);
      set_count(16'h007f);
      chk1("pwm", port1_out[5], 1'b0);
      set_count(16'h0080);
      chk1("pwm", port1_out[5], 1'b1);
      set_count(16'h00ff);
      pulse(1);
      rd(ma(2, offs_value_low), 8'h40);
      chk1("pwm", port1_out[5], 1'b0);
      $display("Test compare finished");
      // Watchdog reset only from module 4; module 3 stays a plain timer
      for (int n = 0; n < 3; n++) wr(ma(n, offs_function), 8'h00);
      wr(addr_mode, m_t0 | 8'h40);
      for (int n = 3; n < 5; n++) begin
         wr(ma(n, offs_value_low), 8'h05);
         wr(ma(n, offs_value_high), 8'h00);
         wr(ma(n, offs_function), 8'h48);
         set_count(16'h0003);
         wd_seen <= 1'b0;
         pulse(2);
         chk1("reset", wd_seen, n == 4);
         if (n == 3) rd(addr_control, 8'h48);
         wr(ma(n, offs_function), 8'h00);
      end
      $display("Test watchdog finished");
      complete_run;
   end
endmodule

`default_nettype wire
